//--- src/smc_top.sv
// SPI controller with mode control register on APB
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"

module smc_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SMC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic sdi,
	output logic sdo,
	output logic sdoOe,
	input wire logic ssnIn,
	output logic spiIrq
);
	import smc_pkg::*;

	function automatic logic [7:0] halfPeriod(input logic [2:0] rate);
		case (rate)
			3'h0: halfPeriod = 8'h02;
			3'h1: halfPeriod = 8'h04;
			3'h2: halfPeriod = 8'h08;
			3'h3: halfPeriod = 8'h10;
			3'h4: halfPeriod = 8'h20;
			3'h5: halfPeriod = 8'h30;
			3'h6: halfPeriod = 8'h40;
			default: halfPeriod = 8'h80;
		endcase
	endfunction

	function automatic logic [`SMC_ADDR_W-1:0] regAddr(input logic [7:0] idx);
		regAddr = {2'b00, idx, 2'b00};
	endfunction

	logic pready_q, pslverr_q, spiIrq_q;
	logic [31:0] prdata_q;
	logic [7:0] mode_q;
	logic [2:0] ctrl_q;
	logic flush_q;
	logic [2:0] sync1_q, sync2_q, sync3_q, filt_q, filtPrev_q;
	smc_byte_t txMem [`SMC_FIFO_DEPTH];
	smc_byte_t rxMem [`SMC_FIFO_DEPTH];
	logic [1:0] txRd_q, txWr_q, rxRd_q, rxWr_q;
	logic [2:0] txCnt_q, rxCnt_q, byteCnt_q, bitCnt_q;
	smc_state_e state_q;
	logic [7:0] div_q;
	smc_byte_t shift_q;
	logic sckOut_q, sckOe_q, sdo_q, sdoOe_q;
	logic [2:0] leadDly_q, capBits_q;
	smc_byte_t rxSh_q;
	logic capture, capDone;
	logic access, wrEn, rdEn, mapped;
	logic txPush, txPop, rxPush, rxPop, txFull, txEmpty, rxFull, rxEmpty;
	logic enabled, isMaster, clock_idle_polarity, dirMsb;
	logic sckF, sdiF, ssnF, sckEdge, ssnFall;
	logic lead, trail, byteDone;
	smc_byte_t rxByte;
	logic [7:0] half;

	assign enabled = ctrl_q[`SMC_CTRL_EN];
	assign isMaster = ctrl_q[`SMC_CTRL_MASTER_SELECT];
	assign clock_idle_polarity = ctrl_q[`SMC_CTRL_CLOCK_IDLE_POLARITY];
	assign dirMsb = mode_q[`SMC_BIT_DIR];
	assign half = halfPeriod(mode_q[`SMC_RATE_HI:`SMC_RATE_LO]);
	assign sckF = filt_q[0];
	assign sdiF = filt_q[1];
	assign ssnF = filt_q[2];
	assign sckEdge = sckF != filtPrev_q[0];
	assign ssnFall = filtPrev_q[2] & ~ssnF;

	// APB decode, one wait state
	assign access = psel & penable & pready_q;
	assign mapped = paddr == regAddr(`SMC_IDX_CTRL) ||
		paddr == regAddr(`SMC_IDX_MODE) ||
		paddr == regAddr(`SMC_IDX_DATA) ||
		paddr == regAddr(`SMC_IDX_STAT);
	assign wrEn = access & pwrite & mapped;
	assign rdEn = access & ~pwrite & mapped;

	assign txFull = txCnt_q == 3'(`SMC_FIFO_DEPTH);
	assign txEmpty = txCnt_q == 3'h0;
	assign rxFull = rxCnt_q == 3'(`SMC_FIFO_DEPTH);
	assign rxEmpty = rxCnt_q == 3'h0;
	assign txPush = wrEn && paddr == regAddr(`SMC_IDX_DATA) && !txFull;
	assign rxPop = rdEn && paddr == regAddr(`SMC_IDX_DATA) && !rxEmpty;

	// Engine edges: master from divider, slave from filtered pin
	always_comb begin
		lead = 1'b0;
		trail = 1'b0;
		if (state_q == SMC_XFER) begin
			if (isMaster) begin
				lead = div_q == 8'h01 && sckOut_q == clock_idle_polarity;
				trail = div_q == 8'h01 && sckOut_q != clock_idle_polarity;
			end else if (!ssnF) begin
				lead = sckEdge && sckF != clock_idle_polarity;
				trail = sckEdge && sckF == clock_idle_polarity;
			end
		end
	end
	assign byteDone = trail && bitCnt_q == 3'h7;
	// Master samples three cycles late, behind the input synchroniser
	assign capture = isMaster ? leadDly_q[2] : lead;
	assign capDone = capture && capBits_q == 3'h7;
	assign rxByte = dirMsb ? {rxSh_q[6:0], sdiF} :
		{sdiF, rxSh_q[7:1]};
	assign rxPush = capDone && !rxFull;
	assign txPop = !txEmpty && ((state_q == SMC_IDLE && enabled &&
		(isMaster || ssnFall)) || (byteDone && !isMaster && !ssnF));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
			prdata_q <= 32'h0;
			if (psel && penable && !pready_q) begin
				if (paddr == regAddr(`SMC_IDX_CTRL))
					prdata_q <= {29'h0, ctrl_q};
				else if (paddr == regAddr(`SMC_IDX_MODE))
					prdata_q <= {24'h0, mode_q};
				else if (paddr == regAddr(`SMC_IDX_DATA))
					prdata_q <= {24'h0, rxMem[rxRd_q]};
				else if (paddr == regAddr(`SMC_IDX_STAT))
					prdata_q <= {27'h0, state_q == SMC_XFER, rxFull,
						rxEmpty, txFull, txEmpty};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `SMC_MODE_RST;
			ctrl_q <= `SMC_CTRL_RST;
			flush_q <= 1'b0;
		end else begin
			flush_q <= 1'b0;
			if (wrEn && paddr == regAddr(`SMC_IDX_MODE)) begin
				mode_q <= pwdata[7:0] & `SMC_MODE_WMASK & ~8'h20;
				flush_q <= pwdata[`SMC_BIT_FLUSH];
			end
			if (wrEn && paddr == regAddr(`SMC_IDX_CTRL))
				ctrl_q <= pwdata[2:0];
		end
	end

	// Pin synchronisers, change accepted when stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 3'h4;
			sync2_q <= 3'h4;
			sync3_q <= 3'h4;
			filt_q <= 3'h4;
			filtPrev_q <= 3'h4;
		end else begin
			sync1_q <= {ssnIn, sdi, sckIn};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= (sync2_q & ~(sync2_q ^ sync3_q)) |
				(filt_q & (sync2_q ^ sync3_q));
			filtPrev_q <= filt_q;
		end
	end

	// Four-byte FIFOs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txRd_q <= 2'h0;
			txWr_q <= 2'h0;
			txCnt_q <= 3'h0;
			rxRd_q <= 2'h0;
			rxWr_q <= 2'h0;
			rxCnt_q <= 3'h0;
		end else if (flush_q) begin
			txRd_q <= 2'h0;
			txWr_q <= 2'h0;
			txCnt_q <= 3'h0;
			rxRd_q <= 2'h0;
			rxWr_q <= 2'h0;
			rxCnt_q <= 3'h0;
		end else begin
			if (txPush) begin
				txMem[txWr_q] <= pwdata[7:0];
				txWr_q <= txWr_q + 2'h1;
			end
			if (txPop)
				txRd_q <= txRd_q + 2'h1;
			txCnt_q <= txCnt_q + 3'(txPush) - 3'(txPop);
			if (rxPush) begin
				rxMem[rxWr_q] <= rxByte;
				rxWr_q <= rxWr_q + 2'h1;
			end
			if (rxPop)
				rxRd_q <= rxRd_q + 2'h1;
			rxCnt_q <= rxCnt_q + 3'(rxPush) - 3'(rxPop);
		end
	end

	// Receive capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			leadDly_q <= 3'h0;
			capBits_q <= 3'h0;
			rxSh_q <= 8'h0;
		end else begin
			leadDly_q <= {leadDly_q[1:0], lead & isMaster};
			if (flush_q || !enabled)
				capBits_q <= 3'h0;
			else if (capture) begin
				capBits_q <= capBits_q + 3'h1;
				rxSh_q <= rxByte;
			end
		end
	end

	// Shift engine
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SMC_IDLE;
			div_q <= 8'h0;
			shift_q <= 8'h0;
			bitCnt_q <= 3'h0;
			sckOut_q <= 1'b0;
			sckOe_q <= 1'b0;
			sdo_q <= 1'b0;
			sdoOe_q <= 1'b0;
		end else begin
			sckOe_q <= enabled & isMaster;
			sdoOe_q <= enabled & (isMaster | ~ssnF);
			unique case (state_q)
				SMC_IDLE: begin
					sckOut_q <= clock_idle_polarity;
					bitCnt_q <= 3'h0;
					div_q <= half;
					if (txPop) begin
						state_q <= SMC_XFER;
						shift_q <= txMem[txRd_q];
						sdo_q <= dirMsb ? txMem[txRd_q][7] :
							txMem[txRd_q][0];
					end
				end
				SMC_XFER: begin
					if (isMaster) begin
						div_q <= (div_q == 8'h01) ? half : div_q - 8'h01;
						if (div_q == 8'h01)
							sckOut_q <= ~sckOut_q;
					end
					if (trail) begin
						bitCnt_q <= bitCnt_q + 3'h1;
						shift_q <= dirMsb ? {shift_q[6:0], 1'b0} :
							{1'b0, shift_q[7:1]};
						sdo_q <= dirMsb ? shift_q[6] : shift_q[1];
					end
					if (byteDone) begin
						if (txPop) begin
							shift_q <= txMem[txRd_q];
							sdo_q <= dirMsb ? txMem[txRd_q][7] :
								txMem[txRd_q][0];
						end else
							state_q <= SMC_IDLE;
					end
					if (!enabled || flush_q || (!isMaster && ssnF))
						state_q <= SMC_IDLE;
				end
			endcase
		end
	end

	// Byte threshold interrupt, one-cycle pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			byteCnt_q <= 3'h0;
			spiIrq_q <= 1'b0;
		end else begin
			spiIrq_q <= 1'b0;
			if (flush_q)
				byteCnt_q <= 3'h0;
			else if (byteDone) begin
				if (byteCnt_q[1:0] == mode_q[`SMC_THR_HI:`SMC_THR_LO]) begin
					spiIrq_q <= 1'b1;
					byteCnt_q <= 3'h0;
				end else
					byteCnt_q <= byteCnt_q + 3'h1;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sckOut = sckOut_q;
	assign sckOe = sckOe_q;
	assign sdo = sdo_q;
	assign sdoOe = sdoOe_q;
	assign spiIrq = spiIrq_q;
endmodule
`default_nettype wire

//--- common/smc_consts.svh
// Offsets, fields, reset values and timing counts of the SPI mode control
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_IDX_CTRL 8'hA0
`define SMC_IDX_MODE 8'hA2
`define SMC_IDX_DATA 8'hA3
`define SMC_IDX_STAT 8'hA4
`define SMC_ADDR_W 12
`define SMC_MODE_RST 8'h00
`define SMC_CTRL_RST 3'h0
`define SMC_MODE_WMASK 8'hEF
`define SMC_BIT_DIR 0
`define SMC_BIT_FLUSH 5
`define SMC_THR_HI 7
`define SMC_THR_LO 6
`define SMC_RATE_HI 3
`define SMC_RATE_LO 1
`define SMC_CTRL_EN 0
`define SMC_CTRL_MASTER_SELECT 1
`define SMC_CTRL_CLOCK_IDLE_POLARITY 2
`define SMC_FIFO_DEPTH 4
`define SMC_SYNC_STAGES 3
`endif

//--- common/smc_pkg.sv
// Types shared by the SPI mode control design
package smc_pkg;
	typedef enum logic {SMC_IDLE, SMC_XFER} smc_state_e;
	typedef logic [7:0] smc_byte_t;
endpackage

//--- bench/smc_top_assertions.sv
// Port assertions of the SPI mode control
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"
module smc_top_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SMC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic spiIrq
);
	localparam logic [11:0] AC = {2'h0, `SMC_IDX_CTRL, 2'h0};
	localparam logic [11:0] AM = {2'h0, `SMC_IDX_MODE, 2'h0};
	localparam int HALF [8] = '{2, 4, 8, 16, 32, 48, 64, 128};
	logic [2:0] ctrlQ;
	logic [7:0] modeQ;
	logic [8:0] cntQ;
	wire logic wr = psel && penable && pready && pwrite;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) ctrlQ <= '0;
		else if (wr && paddr == AC) ctrlQ <= pwdata[2:0];
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) modeQ <= '0;
		else if (wr && paddr == AM) modeQ <= pwdata[7:0] & 8'hCF;
	// Cycles since the serial clock last moved
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) cntQ <= '0;
		else if ($changed(sckOut)) cntQ <= '0;
		else if (!(&cntQ)) cntQ <= cntQ + 9'h1;
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (pready && paddr[11:8] != 4'h2
		|-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	a_mode_readback: assert property (
		pready && !pwrite && paddr == AM |-> prdata == {24'h0, modeQ})
		else $error("mode register readback wrong");
	a_half_period: assert property (
		$changed(sckOut) && sckOe && $past(sckOe) |-> cntQ >= HALF[modeQ[3:1]] - 1)
		else $error("serial clock half period too short");
	a_idle_polarity: assert property ($rose(sckOe) |-> sckOut == ctrlQ[2])
		else $error("idle serial clock level wrong");
	a_oe_master: assert property (
		!(&ctrlQ[1:0]) && !(&$past(ctrlQ[1:0])) |-> !sckOe)
		else $error("clock driven while not master");
	a_irq_pulse: assert property (spiIrq |=> !spiIrq)
		else $error("interrupt pulse too long");
	cover property (spiIrq);
	cover property (pslverr);
	cover property ($rose(sckOe));
endmodule
bind smc_top smc_top_checker i_smc_top_checker (.ref_clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sckOut,
	.sckOe, .spiIrq);
`default_nettype wire

//--- bench/smc_spi_partner.sv
// External SPI slave model on the serial link
`timescale 1ns/1ps
`default_nettype none
module smc_spi_partner (
	input wire logic sck,
	input wire logic clock_idle_polarity,
	input wire logic msbFirst,
	input wire logic sdo,
	input wire logic load,
	input wire logic [7:0] txByte,
	output logic sdi,
	output logic [7:0] rxByte
);
	logic [7:0] sh = '0;
	wire logic lead = sck ^ clock_idle_polarity;
	assign sdi = msbFirst ? sh[7] : sh[0];
	always @(posedge load) sh = txByte;
	always @(posedge lead)
		rxByte = msbFirst ? {rxByte[6:0], sdo} : {sdo, rxByte[7:1]};
	// Spent bits return inverted so the line keeps moving
	always @(negedge lead)
		sh = msbFirst ? {sh[6:0], ~sh[7]} : {~sh[0], sh[7:1]};
endmodule
`default_nettype wire

//--- bench/spi_mode_control_test.sv
// Self-checking bench of the SPI mode control
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin \
	n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module spi_mode_control_test;
	localparam logic [11:0] AC = {2'h0, `SMC_IDX_CTRL, 2'h0};
	localparam logic [11:0] AM = {2'h0, `SMC_IDX_MODE, 2'h0};
	localparam logic [11:0] AD = {2'h0, `SMC_IDX_DATA, 2'h0};
	localparam logic [11:0] AS = {2'h0, `SMC_IDX_STAT, 2'h0};
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, load = 0;
	logic pready, pslverr, sckOut, sckOe, sdi, sdo, spiIrq, err, clock_idle_polarity = 0;
	logic dir = 0, sck = 0, ssn = 1, sdoOe;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [7:0] pByte = '0, tByte, rxByte;
	int n_mismatch = 0, compares = 0, seed = 32'h1CA00038;
	smc_top i_smc_top (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sckIn(sck), .sckOut, .sckOe,
		.sdi, .sdo, .sdoOe, .ssnIn(ssn), .spiIrq);
	smc_spi_partner i_smc_spi_partner (.sck(sckOut), .clock_idle_polarity, .msbFirst(dir),
		.sdo, .load, .txByte(pByte), .sdi, .rxByte);
	initial forever #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] expMode(input logic [7:0] v);
		return {24'h0, v & 8'hCF};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		`CHK("pready", 1'b1, pready)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitIrq(input int lim);
		int n = 0;
		while (spiIrq !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK("irq", 1'b1, spiIrq)
	endtask
	task automatic give_verdict;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(0, AM, 0);
		`CHK("mode reset", 32'h0, rd)
		apb(0, 12'h004, 0);
		`CHK("unmapped", 1'b1, err)
		tByte = $random(seed);
		apb(1, AM, {24'h0, tByte});
		apb(0, AM, 0);
		`CHK("mode rw", expMode(tByte), rd)
		for (int r = 0; r < 8; r++) begin
			clock_idle_polarity <= r[1];
			dir <= r[0];
			apb(1, AC, {29'h0, r[1], 2'b00});
			apb(1, AM, {28'h0, r[2:0], r[0]});
			pByte <= $random(seed);
			tByte = $random(seed);
			load <= 1'b1;
			apb(1, AC, {29'h0, r[1], 2'b11});
			load <= 1'b0;
			apb(1, AD, {24'h0, tByte});
			waitIrq((40 << r) + 100);
			`CHK("partner rx", tByte, rxByte)
			apb(0, AD, 0);
			`CHK("device rx", {24'h0, pByte}, rd)
			`CHK("idle sck", r[1], sckOut)
		end
		dir <= 1'b0;
		apb(1, AM, 32'hE2);
		for (int i = 0; i < 4; i++) apb(1, AD, 32'h10 + i);
		waitIrq(1500);
		`CHK("fourth byte", 8'h13, rxByte)
		apb(1, AC, 0);
		for (int i = 0; i < 4; i++) apb(1, AD, i);
		apb(0, AS, 0);
		`CHK("tx full", 1'b1, rd[1])
		apb(1, AM, 32'h20);
		apb(0, AS, 0);
		`CHK("flushed", 32'h5, rd)
		apb(1, AC, 32'h1);
		apb(1, AD, 32'h5A);
		ssn <= 1'b0;
		repeat (10) @(posedge ref_clk);
		`CHK("slave oe", 2'b01, {sckOe, sdoOe})
		repeat (16) begin
			repeat (8) @(posedge ref_clk);
			sck <= ~sck;
		end
		waitIrq(60);
		ssn <= 1'b1;
		apb(0, AD, 0);
		`CHK("slave rx", {24'h0, {8{sdi}}}, rd)
		give_verdict;
	end
endmodule
`default_nettype wire
